// file: logic/slpc_defines.svh
// offsets, field positions, reset values and counts of the serial lane sequence checker
// assumes inclusion by bare name from the package and the design modules
`ifndef SLPC_DEFINES_SVH
`define SLPC_DEFINES_SVH

// register indices; byte address is four times the index
`define SLPC_IDX_TEST_ENABLE 10'h315
`define SLPC_IDX_TEST_CONTROL 10'h316
`define SLPC_IDX_THRESH_LOW 10'h317
`define SLPC_IDX_THRESH_MID 10'h318
`define SLPC_IDX_THRESH_HIGH 10'h319
`define SLPC_IDX_COUNT_LOW 10'h31a
`define SLPC_IDX_COUNT_MID 10'h31b
`define SLPC_IDX_COUNT_HIGH 10'h31c
`define SLPC_IDX_PASS_STATUS 10'h31d
`define SLPC_IDX_IRQ_STATUS 10'h330
`define SLPC_IDX_IRQ_MASK 10'h331

// bus geometry
`define SLPC_ADDR_W 12
`define SLPC_DATA_W 32
`define SLPC_RESP_OKAY 2'h0
`define SLPC_RESP_SLVERR 2'h2

// control register fields
`define SLPC_CTRL_LANE_SEL_HI 6
`define SLPC_CTRL_LANE_SEL_LO 4
`define SLPC_CTRL_SEQ_SEL_HI 3
`define SLPC_CTRL_SEQ_SEL_LO 2
`define SLPC_CTRL_RUN_BIT 1
`define SLPC_CTRL_CLEAR_BIT 0
`define SLPC_CTRL_WRITE_MASK 8'h7f

// reset values
`define SLPC_ENABLE_RESET 8'h00
`define SLPC_CONTROL_RESET 8'h00
`define SLPC_THRESH_RESET 24'h000000
`define SLPC_PASS_RESET 8'hff
`define SLPC_SEQ_SEL_SHORT 2'h0

// lanes and sequences
`define SLPC_LANES 8
`define SLPC_COUNT_W 24
`define SLPC_COUNT_MAX 24'hffffff
`define SLPC_SR_W 31
`define SLPC_SHORT_TAP_A 6
`define SLPC_SHORT_TAP_B 5
`define SLPC_LONG_TAP_A 30
`define SLPC_LONG_TAP_B 27
`define SLPC_SHORT_FILL 5'h07
`define SLPC_LONG_FILL 5'h1f

`endif

// file: logic/slpc_pkg.sv
// types shared by the serial lane sequence checker
// assumes slpc_defines.svh is on the include path
`include "slpc_defines.svh"

package slpc_pkg;

  typedef enum logic [1:0] {
    slpc_st_idle,
    slpc_st_run,
    slpc_st_clear
  } slpc_state_type;

  typedef logic [`SLPC_COUNT_W-1:0] slpc_count_type;

endpackage

// file: logic/slpc_lane_checker.sv
// one lane's self-seeding sequence checker with saturating mismatch counter
// assumes lane bits are synchronous to aclk and qualified by lane_valid
`include "slpc_defines.svh"

module slpc_lane_checker
  import slpc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic check_run,
  input wire logic check_clear,
  input wire logic seq_long,
  input wire slpc_count_type threshold,
  input wire logic lane_bit,
  input wire logic lane_valid,
  output slpc_count_type err_count,
  output logic lane_pass
);

  logic [`SLPC_SR_W-1:0] history_q;
  logic [4:0] fill_q;
  logic predicted;
  logic seeded;
  logic step;

  assign predicted = seq_long ? (history_q[`SLPC_LONG_TAP_A] ^ history_q[`SLPC_LONG_TAP_B])
                              : (history_q[`SLPC_SHORT_TAP_A] ^ history_q[`SLPC_SHORT_TAP_B]);
  assign seeded = fill_q >= (seq_long ? `SLPC_LONG_FILL : `SLPC_SHORT_FILL);
  assign step = check_run && lane_valid;

  ////////////////////////////////////////////////////////////////////////
  // reference history; first bits only seed it, no comparison yet
  always_ff @(posedge aclk) begin
    if (!aresetn || check_clear) begin
      history_q <= '0;
      fill_q <= 5'h00;
    end else if (step) begin
      history_q <= {history_q[`SLPC_SR_W-2:0], lane_bit};
      if (!seeded) begin
        fill_q <= fill_q + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // count saturates so a long run never wraps back under threshold
  always_ff @(posedge aclk) begin
    if (!aresetn || check_clear) begin
      err_count <= '0;
    end else if (step && seeded && (lane_bit != predicted) && (err_count != `SLPC_COUNT_MAX)) begin
      err_count <= err_count + 24'h000001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || check_clear) begin
      lane_pass <= 1'b1;
    end else if (err_count > threshold) begin
      lane_pass <= 1'b0;
    end
  end

endmodule // slpc_lane_checker

// file: logic/slpc_top.sv
// serial lane sequence checker: eight lane checkers behind an AXI4-Lite register slave
// assumes one clock, synchronous active-low reset, lane bits synchronous to aclk
//
// Register access over AXI4-Lite is this design's own decision.
`include "slpc_defines.svh"

module slpc_top
  import slpc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`SLPC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`SLPC_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SLPC_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`SLPC_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`SLPC_LANES-1:0] lane_bits,
  input wire logic [`SLPC_LANES-1:0] lane_valid,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [9:0] word_index(input logic [`SLPC_ADDR_W-1:0] addr);
    word_index = addr[`SLPC_ADDR_W-1:2];
  endfunction

  function automatic logic index_mapped(input logic [9:0] idx);
    case (idx)
      `SLPC_IDX_TEST_ENABLE, `SLPC_IDX_TEST_CONTROL,
      `SLPC_IDX_THRESH_LOW, `SLPC_IDX_THRESH_MID, `SLPC_IDX_THRESH_HIGH,
      `SLPC_IDX_COUNT_LOW, `SLPC_IDX_COUNT_MID, `SLPC_IDX_COUNT_HIGH,
      `SLPC_IDX_PASS_STATUS, `SLPC_IDX_IRQ_STATUS, `SLPC_IDX_IRQ_MASK: index_mapped = 1'b1;
      default: index_mapped = 1'b0;
    endcase
  endfunction

  // picks byte k of a 24-bit value; shared by threshold and count reads
  function automatic logic [7:0] byte_of(input slpc_count_type v, input logic [1:0] k);
    case (k)
      2'h0: byte_of = v[7:0];
      2'h1: byte_of = v[15:8];
      default: byte_of = v[23:16];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers and wires

  logic [7:0] test_enable_q;
  logic [7:0] test_control_q;
  slpc_count_type threshold_q;
  logic [7:0] irq_status_q;
  logic [7:0] irq_mask_q;
  logic [7:0] pass_prev_q;
  slpc_state_type state_q;
  slpc_state_type state_d;

  logic aw_held_q;
  logic w_held_q;
  logic [`SLPC_ADDR_W-1:0] aw_addr_q;
  logic [`SLPC_DATA_W-1:0] w_data_q;
  logic [3:0] w_strb_q;

  logic [2:0] count_lane_select;
  logic [1:0] sequence_select;
  logic checker_run;
  logic checker_clear;
  logic checker_clock_ungate;
  logic lanes_active;
  logic seq_long;

  slpc_count_type lane_count [`SLPC_LANES];
  logic [`SLPC_LANES-1:0] lane_pass_flags;
  slpc_count_type selected_count;
  logic [7:0] fail_events;

  logic write_fire;
  logic [9:0] wr_idx;
  logic wr_ok;
  logic read_fire;
  logic [9:0] rd_idx;
  logic status_read;
  logic [`SLPC_DATA_W-1:0] rd_value;

  ////////////////////////////////////////////////////////////////////////
  // control fields

  assign count_lane_select = test_control_q[`SLPC_CTRL_LANE_SEL_HI:`SLPC_CTRL_LANE_SEL_LO];
  assign sequence_select = test_control_q[`SLPC_CTRL_SEQ_SEL_HI:`SLPC_CTRL_SEQ_SEL_LO];
  assign checker_run = test_control_q[`SLPC_CTRL_RUN_BIT];
  assign checker_clear = test_control_q[`SLPC_CTRL_CLEAR_BIT];
  // any nonzero value ungates, so software writing 0x01 or 0xff both work
  assign checker_clock_ungate = test_enable_q != 8'h00;
  assign seq_long = sequence_select != `SLPC_SEQ_SEL_SHORT;
  // gating modelled as a qualifier: with no ungate the lanes hold history and counts, but clear still resets them
  assign lanes_active = checker_clock_ungate && (state_q == slpc_st_run);

  ////////////////////////////////////////////////////////////////////////
  // test state machine
  // clear wins over run; leaving clear always passes through idle

  always_comb begin
    state_d = state_q;
    case (state_q)
      slpc_st_idle: begin
        if (checker_clear) begin
          state_d = slpc_st_clear;
        end else if (checker_run && checker_clock_ungate) begin
          state_d = slpc_st_run;
        end
      end
      slpc_st_run: begin
        if (checker_clear) begin
          state_d = slpc_st_clear;
        end else if (!checker_run || !checker_clock_ungate) begin
          state_d = slpc_st_idle;
        end
      end
      slpc_st_clear: begin
        if (!checker_clear) begin
          state_d = slpc_st_idle;
        end
      end
      default: begin
        state_d = slpc_st_idle;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= slpc_st_idle;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lane checkers

  for (genvar g = 0; g < `SLPC_LANES; g++) begin : g_lane
    slpc_lane_checker u_lane (
      .aclk(aclk),
      .aresetn(aresetn),
      .check_run(lanes_active),
      .check_clear(checker_clear),
      .seq_long(seq_long),
      .threshold(threshold_q),
      .lane_bit(lane_bits[g]),
      .lane_valid(lane_valid[g]),
      .err_count(lane_count[g]),
      .lane_pass(lane_pass_flags[g])
    );
  end

  assign selected_count = lane_count[count_lane_select];

  ////////////////////////////////////////////////////////////////////////
  // axi write channel: address and data taken in either order
  // a held-off bready lets the next address in early; it waits for the response

  assign write_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_idx = word_index(aw_addr_q);
  assign wr_ok = index_mapped(wr_idx);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (write_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (write_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SLPC_RESP_OKAY;
    end else if (write_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `SLPC_RESP_OKAY : `SLPC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // writable registers; only byte lane 0 carries data
  // threshold bytes land one write at a time; a running lane sees each partial value

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_enable_q <= `SLPC_ENABLE_RESET;
      test_control_q <= `SLPC_CONTROL_RESET;
      threshold_q <= `SLPC_THRESH_RESET;
      irq_mask_q <= 8'h00;
    end else if (write_fire && w_strb_q[0]) begin
      case (wr_idx)
        `SLPC_IDX_TEST_ENABLE: test_enable_q <= w_data_q[7:0];
        `SLPC_IDX_TEST_CONTROL: test_control_q <= w_data_q[7:0] & `SLPC_CTRL_WRITE_MASK;
        `SLPC_IDX_THRESH_LOW: threshold_q[7:0] <= w_data_q[7:0];
        `SLPC_IDX_THRESH_MID: threshold_q[15:8] <= w_data_q[7:0];
        `SLPC_IDX_THRESH_HIGH: threshold_q[23:16] <= w_data_q[7:0];
        `SLPC_IDX_IRQ_MASK: irq_mask_q <= w_data_q[7:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi read channel
  // awprot and arprot are not decoded: every access is treated alike
  // unmapped words read as zero and answer with a slave error

  assign read_fire = s_axi_arvalid && s_axi_arready;
  assign rd_idx = word_index(s_axi_araddr);
  assign status_read = read_fire && (rd_idx == `SLPC_IDX_IRQ_STATUS);

  always_comb begin
    rd_value = '0;
    case (rd_idx)
      `SLPC_IDX_TEST_ENABLE: rd_value[7:0] = test_enable_q;
      `SLPC_IDX_TEST_CONTROL: rd_value[7:0] = test_control_q;
      `SLPC_IDX_THRESH_LOW: rd_value[7:0] = byte_of(threshold_q, 2'h0);
      `SLPC_IDX_THRESH_MID: rd_value[7:0] = byte_of(threshold_q, 2'h1);
      `SLPC_IDX_THRESH_HIGH: rd_value[7:0] = byte_of(threshold_q, 2'h2);
      `SLPC_IDX_COUNT_LOW: rd_value[7:0] = byte_of(selected_count, 2'h0);
      `SLPC_IDX_COUNT_MID: rd_value[7:0] = byte_of(selected_count, 2'h1);
      `SLPC_IDX_COUNT_HIGH: rd_value[7:0] = byte_of(selected_count, 2'h2);
      `SLPC_IDX_PASS_STATUS: rd_value[7:0] = lane_pass_flags;
      `SLPC_IDX_IRQ_STATUS: rd_value[7:0] = irq_status_q;
      `SLPC_IDX_IRQ_MASK: rd_value[7:0] = irq_mask_q;
      default: rd_value = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !read_fire;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `SLPC_RESP_OKAY;
    end else if (read_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= index_mapped(rd_idx) ? `SLPC_RESP_OKAY : `SLPC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt: a lane falling from pass to fail is the event
  // pass falls one edge after the count crosses; irq trails status by one more

  assign fail_events = pass_prev_q & ~lane_pass_flags;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pass_prev_q <= `SLPC_PASS_RESET;
    end else begin
      pass_prev_q <= lane_pass_flags;
    end
  end

  // a new event in the clearing read's cycle survives the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_q <= 8'h00;
    end else if (status_read) begin
      irq_status_q <= fail_events;
    end else begin
      irq_status_q <= irq_status_q | fail_events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_q & irq_mask_q);
    end
  end

endmodule // slpc_top

// file: test/slpc_asserts.sv
// register-port checker for slpc_top
// assumes one clock domain and binding to slpc_top by the bind below
`include "slpc_defines.svh"
module slpc_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`SLPC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SLPC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [`SLPC_DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read response dropped early");
  property p_wresp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid; endproperty
  a_wresp: assert property (p_wresp) else $error("write response late");
  property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rresp: assert property (p_rresp) else $error("read response late");
  property p_wbusy; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  a_wbusy: assert property (p_wbusy) else $error("write address taken while one is held");
  property p_wdbusy; s_axi_wvalid && s_axi_wready |=> !s_axi_wready; endproperty
  a_wdbusy: assert property (p_wdbusy) else $error("write data taken while one is held");
  property p_rbusy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rbusy: assert property (p_rbusy) else $error("read taken while data pending");
  property p_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  property p_werr; s_axi_awvalid && s_axi_awready && s_axi_awaddr == 12'h0 |=> ##[0:3] s_axi_bvalid
    && s_axi_bresp == `SLPC_RESP_SLVERR; endproperty
  a_werr: assert property (p_werr) else $error("unmapped write not refused");
  property p_rerr; s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h0 |=> s_axi_rdata == 32'h0
    && s_axi_rresp == `SLPC_RESP_SLVERR; endproperty
  a_rerr: assert property (p_rerr) else $error("unmapped read not refused");
  property p_rsvd; s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'hc58 |=> !s_axi_rdata[7]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved control bit reads one");
endmodule // slpc_asserts

bind slpc_top slpc_asserts u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// file: test/slpc_lane_tx.sv
// far-end transmitter: same sequence on all eight lanes, every cycle
// assumes flip is a one-cycle pulse that inverts one sent bit per lane
module slpc_lane_tx (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic seq_long,
  input wire logic [7:0] flip,
  output logic [7:0] lane_bits,
  output logic [7:0] lane_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] sr7_q = 7'h7f;
  logic [30:0] sr31_q = 31'h7fffffff;
  initial lane_bits = 8'h00;
  initial lane_valid = 8'h00;
  ////////////////////////////////////////
  // runs free, so the checker may start at any point of the stream
  always @(posedge aclk) begin
    sr7_q <= {sr7_q[5:0], sr7_q[6] ^ sr7_q[5]};
    sr31_q <= {sr31_q[29:0], sr31_q[30] ^ sr31_q[27]};
    lane_valid <= {8{aresetn}};
    if (!aresetn)
      lane_bits <= ~lane_bits;
    else
      lane_bits <= {8{seq_long ? sr31_q[30] ^ sr31_q[27] : sr7_q[6] ^ sr7_q[5]}} ^ flip;
  end
endmodule // slpc_lane_tx

// file: test/slpc_top_tb.sv
// self-checking bench for slpc_top over its register port
// assumes slpc_lane_tx as far end and the bound checker
`include "slpc_defines.svh"
module slpc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, seq_long;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [`SLPC_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] flip, lane_bits, lane_valid;
  int fail_count, n_compared;

  slpc_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lane_bits, .lane_valid, .irq);
  slpc_lane_tx u_tx (.aclk, .aresetn, .seq_long, .flip, .lane_bits, .lane_valid);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  ////////////////////////////////////////
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // every wait is bounded; a hang ends the run
  task automatic guard(input int n);
    if (n >= 300) begin
      fail_count++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] e = 2'h0);
    int n;
    logic aw_go, w_go;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // each channel is released at the edge that takes it
    do begin
      @(negedge aclk);
      aw_go = s_axi_awvalid && s_axi_awready === 1'b1;
      w_go = s_axi_wvalid && s_axi_wready === 1'b1;
      @(posedge aclk);
      if (aw_go) s_axi_awvalid <= 1'b0;
      if (w_go) s_axi_wvalid <= 1'b0;
    end while (!((aw_go || !s_axi_awvalid) && (w_go || !s_axi_wvalid)) && ++n < 300);
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1 && ++n < 300);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, e});
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    guard(n);
  endtask

  task automatic rc(input logic [9:0] i, input logic [7:0] e, input logic [1:0] r = 2'h0);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1 && ++n < 300);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1 && ++n < 300);
    chk("rdata", s_axi_rdata, {24'h0, e});
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, r});
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    guard(n);
  endtask

  // one inverted bit per masked lane, then time for its echoes
  task automatic fl(input logic [7:0] m);
    @(posedge aclk);
    flip <= m;
    @(posedge aclk);
    flip <= 8'h00;
    repeat (40) @(posedge aclk);
  endtask
  ////////////////////////////////////////
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, seq_long} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    flip = 8'h00;
    fail_count = 0;
    n_compared = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 9; i++) rc(10'h315 + 10'(i), (i == 8) ? 8'hff : 8'h00);
    rc(10'h331, 8'h00);
    wr(10'h318, 8'ha5);
    wr(10'h319, 8'h5a);
    wr(10'h317, 8'h04);
    rc(10'h318, 8'ha5);
    rc(10'h319, 8'h5a);
    wr(10'h318, 8'h00);
    wr(10'h319, 8'h00);
    wr(10'h31a, 8'h55);
    rc(10'h31a, 8'h00);
    wr(10'h000, 8'h11, `SLPC_RESP_SLVERR);
    rc(10'h000, 8'h00, `SLPC_RESP_SLVERR);
    wr(10'h316, 8'hfe);
    rc(10'h316, 8'h7e);
    fl(8'hff);
    rc(10'h31a, 8'h00);
    wr(10'h316, 8'h00);
    wr(10'h315, 8'h01);
    fl(8'hff);
    rc(10'h31a, 8'h00);
    wr(10'h331, 8'hfb);
    for (int c = 0; c < 4; c++) begin
      wr(10'h316, 8'(c * 4 + 1));
      // switch the far stream only while the lanes are held clear
      seq_long <= (c != 0);
      rc(10'h31a, 8'h00);
      rc(10'h31d, 8'hff);
      wr(10'h316, 8'(32 + c * 4 + 2));
      repeat (64) @(posedge aclk);
      fl(8'h04);
      rc(10'h31a, 8'h03);
      rc(10'h31d, 8'hff);
      fl(8'h04);
      rc(10'h31a, 8'h06);
      rc(10'h31d, 8'hfb);
      chk("irq", {31'h0, irq}, {31'h0, c != 0});
      rc(10'h330, 8'h04);
      rc(10'h330, 8'h00);
      chk("irq", {31'h0, irq}, 32'h0);
      wr(10'h331, 8'hff);
      for (int l = 0; l < 8; l++) begin
        wr(10'h316, 8'(l * 16 + c * 4 + 2));
        rc(10'h31a, (l == 2) ? 8'h06 : 8'h00);
      end
      rc(10'h31b, 8'h00);
      rc(10'h31c, 8'h00);
    end
    wr(10'h316, 8'h2c);
    fl(8'h04);
    rc(10'h31a, 8'h06);
    stop_test();
  end
endmodule // slpc_top_tb
